// [common/lsmc_cfg.svh]
// Constants of the LIN system basis chip mode controller
`ifndef LSMC_CFG_SVH
`define LSMC_CFG_SVH
`define LSMC_CLK_HZ 20000000
`define LSMC_STBY_TO_MS 350
`define LSMC_IGN_FILT_US 250
`define LSMC_BUS_FILT_US 50
`define LSMC_PIN_FILT_US 50
`define LSMC_DOM_TO_US 10000
`define LSMC_CNT_W 24
`define LSMC_CTRL_OFS 4'h0
`define LSMC_STATUS_OFS 4'h4
`define LSMC_CTRL_MASK_BIT 0
`define LSMC_CTRL_RST 1'h0
`define LSMC_ST_MODE_LSB 0
`define LSMC_ST_SLEW_BIT 4
`define LSMC_ST_WREQ_BIT 5
`define LSMC_ST_WLOC_BIT 6
`define LSMC_ST_TXARM_BIT 7
`define LSMC_ST_TXTO_BIT 8
`define LSMC_ST_LVAR_BIT 9
`define LSMC_IN_W 11
`define LSMC_IN_EN 0
`define LSMC_IN_TXD 1
`define LSMC_IN_BUS 2
`define LSMC_IN_PIN 3
`define LSMC_IN_IGN 4
`define LSMC_IN_SOK 5
`define LSMC_IN_TRIP 6
`define LSMC_IN_VLOW 7
`define LSMC_IN_AUX 8
`define LSMC_IN_TRIM 9
`define LSMC_IN_LVAR 10
`endif

// [common/lsmc_pkg.sv]
// Types of the LIN system basis chip mode controller
`include "lsmc_cfg.svh"
package lsmc_pkg;
  typedef enum logic [2:0] {LSMC_INIT, LSMC_STANDBY, LSMC_NORMAL, LSMC_SILENT, LSMC_SLEEP} lsmc_mode_t;
  typedef struct packed {
    logic aux_en;
    logic osc_en;
    logic reg_en;
    logic tx_dom;
    logic low_slew;
    logic rxd_oe;
    logic txd_oe;
    logic term_en;
    logic bias_en;
    logic supply_inhibit_output;
  } lsmc_pins_t;
  typedef struct packed {
    lsmc_mode_t mode;
    logic aux_ok;
    logic [`LSMC_CNT_W-1:0] tmr;
    logic slew_seen;
    logic low_slew;
    logic tx_armed;
    logic tx_to;
    logic [`LSMC_CNT_W-1:0] dom_cnt;
    logic [`LSMC_CNT_W-1:0] bus_cnt;
    logic bus_arm;
    logic [`LSMC_CNT_W-1:0] pin_cnt;
    logic pin_arm;
    logic [`LSMC_CNT_W-1:0] ign_cnt;
    logic ign_ready;
    logic wake_req;
    logic wake_local;
    logic local_var;
    logic mask;
    logic [`LSMC_IN_W-1:0] s1;
    logic [`LSMC_IN_W-1:0] s2;
    logic [`LSMC_IN_W-1:0] s3;
    logic waitreq;
    logic [31:0] rdata;
    lsmc_pins_t po;
  } lsmc_state_t;
endpackage : lsmc_pkg

// [rtl/lsmc_top.sv]
// Operating-mode controller of a LIN system basis chip with Avalon-MM status access
// Functional notes
// - Supply rising above release level enters Standby without microcontroller action.
// - Aux supply POR and oscillator start first; regulator starts after POR.
// - Standby after power-up: transmitter, receiver off, receive pin floats, pull-up on.
// - Standby times out after 350 ms to Sleep unless enable rises.
// - Valid wake in Sleep or Silent enters Standby, receive pin pulled low.
// - Normal: everything active, transmit up to 20 kbit/s, bus forwarded to receive pin.
// - Normal, enable falling: Silent if transmit pin high, else Sleep.
// - Regulated supply low in Normal or Silent returns to Standby.
// - First enable rise after power-on samples transmit pin; low picks low slew.
// - Low slew reduces slope; microcontroller keeps to 10.4 kbit/s.
// - Silent: regulator on, transmitter off, receive pin floats, weak bias only.
// - Silent: enable rise returns to Normal; wake goes to Standby.
// - Sleep: regulator off, transmitter off, receive pin released, termination off.
// - Sleep left only by remote or local wake, into Standby, or by a supply trip, into Init.
// - Supply switch-on or trip below trip level enters Init from any mode.
// - Init ramps aux supply, reads trim, then passes to Standby with regulator.
// - Remote wake: bus falls, dominant beyond filter, takes effect on rising edge.
// - Local pin falling then low beyond filter raises local wake.
// - Ignition rising then high beyond 250 us raises local wake.
// - Next ignition wake needs low beyond 250 us; steady high ignores modes.
// - Local wake sets source flag, shown by pulling transmit pin low in Standby.
// - Enable high clears wake request and source flag together.
// - Variant without local inputs wakes by bus only, never drives source flag.
// - Dominant transmit beyond timeout disables path; counter restarts on falling edge.
// - Inhibit output high in Standby and Normal on local variant, else off.
`timescale 1ns/100ps
`default_nettype none
`include "lsmc_cfg.svh"
module lsmc_top #(
  parameter int STBY_CYC = `LSMC_STBY_TO_MS * (`LSMC_CLK_HZ / 1000),
  parameter int IGN_CYC = `LSMC_IGN_FILT_US * (`LSMC_CLK_HZ / 1000000),
  parameter int BUS_CYC = `LSMC_BUS_FILT_US * (`LSMC_CLK_HZ / 1000000),
  parameter int PIN_CYC = `LSMC_PIN_FILT_US * (`LSMC_CLK_HZ / 1000000),
  parameter int DOM_CYC = `LSMC_DOM_TO_US * (`LSMC_CLK_HZ / 1000000)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mode_select_i,
  input wire logic txd_i,
  input wire logic bus_level_i,
  input wire logic wake_pin_i,
  input wire logic ignition_wake_i,
  input wire logic supply_ok_i,
  input wire logic supply_trip_i,
  input wire logic vcc_low_i,
  input wire logic aux_por_done_i,
  input wire logic trim_done_i,
  input wire logic trim_local_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output lsmc_pkg::lsmc_pins_t pins_o
);
  localparam int CMAX = (1 << `LSMC_CNT_W) - 1;
  localparam logic [`LSMC_CNT_W-1:0] STBY_END = `LSMC_CNT_W'(STBY_CYC - 1);
  localparam logic [`LSMC_CNT_W-1:0] IGN_END = `LSMC_CNT_W'(IGN_CYC);
  localparam logic [`LSMC_CNT_W-1:0] BUS_END = `LSMC_CNT_W'(BUS_CYC);
  localparam logic [`LSMC_CNT_W-1:0] PIN_END = `LSMC_CNT_W'(PIN_CYC);
  localparam logic [`LSMC_CNT_W-1:0] DOM_END = `LSMC_CNT_W'(DOM_CYC);

  // Counters are a fixed width, so a count that does not fit is refused
  if (STBY_CYC < 1 || IGN_CYC < 1 || BUS_CYC < 1 || PIN_CYC < 1 || DOM_CYC < 1 ||
      STBY_CYC > CMAX || IGN_CYC >= CMAX || BUS_CYC >= CMAX || PIN_CYC >= CMAX || DOM_CYC >= CMAX) begin : g_chk
    $error("lsmc_top: cycle count out of range");
  end

  lsmc_pkg::lsmc_state_t q;
  lsmc_pkg::lsmc_state_t d;
  logic [`LSMC_IN_W-1:0] pins_in;
  logic en, en_rise, en_fall, txd, bus, pin, ign, trip, vlow;
  logic bus_fall, bus_rise, rwake, pwake, iwake, lwake, wake, wake_set;
  logic req;
  logic [31:0] status;

  // Every pin and monitor comes from another domain, so all pass two flops
  assign pins_in = {trim_local_i, trim_done_i, aux_por_done_i, vcc_low_i, supply_trip_i, supply_ok_i,
                    ignition_wake_i, wake_pin_i, bus_level_i, txd_i, mode_select_i};

  // Edges compare the second sync stage with its delayed copy
  assign en = q.s2[`LSMC_IN_EN];
  assign en_rise = en & ~q.s3[`LSMC_IN_EN];
  assign en_fall = ~en & q.s3[`LSMC_IN_EN];
  assign txd = q.s2[`LSMC_IN_TXD];
  assign bus = q.s2[`LSMC_IN_BUS];
  assign bus_fall = ~bus & q.s3[`LSMC_IN_BUS];
  assign bus_rise = bus & ~q.s3[`LSMC_IN_BUS];
  assign pin = q.s2[`LSMC_IN_PIN];
  assign ign = q.s2[`LSMC_IN_IGN];
  assign trip = q.s2[`LSMC_IN_TRIP];
  assign vlow = q.s2[`LSMC_IN_VLOW];

  // Wake qualification; local sources only count on the local variant
  assign rwake = bus_rise & q.bus_arm & (q.bus_cnt >= BUS_END);
  assign pwake = q.pin_arm & ~pin & (q.pin_cnt == PIN_END);
  assign iwake = q.ign_ready & ign & (q.ign_cnt == IGN_END);
  assign lwake = q.local_var & ~q.mask & (pwake | iwake);
  assign wake = rwake | lwake;
  assign wake_set = wake & ~trip & (q.mode == lsmc_pkg::LSMC_SLEEP || q.mode == lsmc_pkg::LSMC_SILENT);
  assign req = avs_read_i | avs_write_i;

  // Status word built from live state
  always_comb begin
    status = 32'h0000_0000;
    status[`LSMC_ST_MODE_LSB +: 3] = q.mode;
    status[`LSMC_ST_SLEW_BIT] = q.low_slew;
    status[`LSMC_ST_WREQ_BIT] = q.wake_req;
    status[`LSMC_ST_WLOC_BIT] = q.wake_local;
    status[`LSMC_ST_TXARM_BIT] = q.tx_armed;
    status[`LSMC_ST_TXTO_BIT] = q.tx_to;
    status[`LSMC_ST_LVAR_BIT] = q.local_var;
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;

    // Remote wake filter: armed by a falling edge, timed while dominant
    if (bus_fall) begin
      d.bus_arm = 1'b1;
      d.bus_cnt = '0;
    end else if (bus_rise) begin
      d.bus_arm = 1'b0;
    end else if (~bus && q.bus_cnt != BUS_END) begin
      d.bus_cnt = q.bus_cnt + 1'b1;
    end

    // Local pin filter fires once per falling edge
    if (pin) begin
      d.pin_arm = 1'b0;
    end else if (q.s3[`LSMC_IN_PIN]) begin
      d.pin_arm = 1'b1;
      d.pin_cnt = '0;
    end else if (pwake) begin
      d.pin_arm = 1'b0;
    end else begin
      d.pin_cnt = q.pin_cnt + 1'b1;
    end

    // Ignition: level time counted from each edge; low re-arms, high fires once
    if (ign != q.s3[`LSMC_IN_IGN]) begin
      d.ign_cnt = '0;
    end else if (q.ign_cnt != IGN_END) begin
      d.ign_cnt = q.ign_cnt + 1'b1;
    end else if (~ign) begin
      d.ign_ready = 1'b1;
    end else if (iwake) begin
      d.ign_ready = 1'b0;
    end

    // Slew choice latched once, dropped with the supply
    if (en_rise && !q.slew_seen) begin
      d.slew_seen = 1'b1;
      d.low_slew = ~txd;
    end
    if (!q.s2[`LSMC_IN_SOK]) begin
      d.low_slew = 1'b0;
    end

    // Transmit path enable and dominant timeout
    if (q.mode != lsmc_pkg::LSMC_NORMAL) begin
      d.tx_armed = 1'b0;
      d.tx_to = 1'b0;
      d.dom_cnt = '0;
    end else if (txd) begin
      d.tx_armed = 1'b1;
      d.tx_to = 1'b0;
      d.dom_cnt = '0;
    end else if (q.s3[`LSMC_IN_TXD]) begin
      d.dom_cnt = '0;
    end else if (q.dom_cnt == DOM_END) begin
      d.tx_to = q.tx_armed;
    end else begin
      d.dom_cnt = q.dom_cnt + 1'b1;
    end

    // Wake flags: a new event wins over the clear by enable high
    d.wake_req = wake_set | (q.wake_req & ~en);
    d.wake_local = (wake_set & lwake) | (q.wake_local & ~en);

    // Mode sequencing
    d.tmr = '0;
    if (trip) begin
      d.mode = lsmc_pkg::LSMC_INIT;
      d.aux_ok = 1'b0;
      d.slew_seen = 1'b0;
      d.low_slew = 1'b0;
      d.wake_req = 1'b0;
      d.wake_local = 1'b0;
    end else begin
      unique case (q.mode)
        lsmc_pkg::LSMC_INIT: begin
          if (q.s2[`LSMC_IN_AUX]) begin
            d.aux_ok = 1'b1;
          end
          if (q.aux_ok && q.s2[`LSMC_IN_TRIM] && q.s2[`LSMC_IN_SOK]) begin
            d.local_var = q.s2[`LSMC_IN_LVAR];
            d.mode = lsmc_pkg::LSMC_STANDBY;
          end
        end
        lsmc_pkg::LSMC_STANDBY: begin
          if (en_rise) begin
            d.mode = lsmc_pkg::LSMC_NORMAL;
          end else if (q.tmr == STBY_END) begin
            d.mode = lsmc_pkg::LSMC_SLEEP;
          end else begin
            d.tmr = q.tmr + 1'b1;
          end
        end
        lsmc_pkg::LSMC_NORMAL: begin
          if (vlow) begin
            d.mode = lsmc_pkg::LSMC_STANDBY;
          end else if (en_fall) begin
            d.mode = txd ? lsmc_pkg::LSMC_SILENT : lsmc_pkg::LSMC_SLEEP;
          end
        end
        lsmc_pkg::LSMC_SILENT: begin
          if (vlow || wake) begin
            d.mode = lsmc_pkg::LSMC_STANDBY;
          end else if (en_rise) begin
            d.mode = lsmc_pkg::LSMC_NORMAL;
          end
        end
        lsmc_pkg::LSMC_SLEEP: begin
          if (wake) begin
            d.mode = lsmc_pkg::LSMC_STANDBY;
          end
        end
      endcase
    end

    // Pin controls follow the next mode so they settle with it
    d.po.aux_en = 1'b1;
    d.po.osc_en = 1'b1;
    d.po.reg_en = (d.mode != lsmc_pkg::LSMC_SLEEP) && (d.mode != lsmc_pkg::LSMC_INIT || d.aux_ok);
    d.po.tx_dom = (d.mode == lsmc_pkg::LSMC_NORMAL) & d.tx_armed & ~d.tx_to & ~txd;
    d.po.low_slew = d.low_slew;
    d.po.rxd_oe = ((d.mode == lsmc_pkg::LSMC_NORMAL) & ~bus) |
                  ((d.mode == lsmc_pkg::LSMC_STANDBY) & d.wake_req);
    d.po.txd_oe = (d.mode == lsmc_pkg::LSMC_STANDBY) & d.wake_local & d.local_var;
    d.po.term_en = (d.mode != lsmc_pkg::LSMC_SILENT) && (d.mode != lsmc_pkg::LSMC_SLEEP);
    d.po.bias_en = (d.mode == lsmc_pkg::LSMC_SILENT) || (d.mode == lsmc_pkg::LSMC_SLEEP);
    d.po.supply_inhibit_output = d.local_var && (d.mode == lsmc_pkg::LSMC_STANDBY || d.mode == lsmc_pkg::LSMC_NORMAL);

    // Avalon slave: answer one cycle after the request, unmapped reads give zero
    d.waitreq = ~(req & q.waitreq);
    if (req && q.waitreq) begin
      d.rdata = 32'h0000_0000;
      if (avs_read_i && avs_address_i == `LSMC_CTRL_OFS) begin
        d.rdata[`LSMC_CTRL_MASK_BIT] = q.mask;
      end else if (avs_read_i && avs_address_i == `LSMC_STATUS_OFS) begin
        d.rdata = status;
      end
    end
    if (avs_write_i && !q.waitreq && avs_address_i == `LSMC_CTRL_OFS) begin
      d.mask = avs_writedata_i[`LSMC_CTRL_MASK_BIT];
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.mode <= lsmc_pkg::LSMC_INIT;
      q.mask <= `LSMC_CTRL_RST;
      q.waitreq <= 1'b1;
      q.po.aux_en <= 1'b1;
      q.po.osc_en <= 1'b1;
      q.po.term_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.waitreq;
  assign pins_o = q.po;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_stby_sleep_to: assert property (q.mode == lsmc_pkg::LSMC_STANDBY && q.tmr == STBY_END && !en_rise && !trip
    |=> q.mode == lsmc_pkg::LSMC_SLEEP && !pins_o.reg_en) else $error("standby timeout missed");
  a_trip_init: assert property (trip |=> q.mode == lsmc_pkg::LSMC_INIT && !q.low_slew)
    else $error("supply trip did not reach init");
  a_norm_en_fall: assert property (q.mode == lsmc_pkg::LSMC_NORMAL && en_fall && !vlow && !trip
    |=> q.mode == (($past(txd)) ? lsmc_pkg::LSMC_SILENT : lsmc_pkg::LSMC_SLEEP)) else $error("bad exit from normal");
  a_wake_irq: assert property (wake_set |=> q.mode == lsmc_pkg::LSMC_STANDBY && pins_o.rxd_oe)
    else $error("wake not signalled");
  a_silent_en_rise: assert property (q.mode == lsmc_pkg::LSMC_SILENT && en_rise && !vlow && !wake && !trip
    |=> q.mode == lsmc_pkg::LSMC_NORMAL) else $error("silent did not return to normal");
  a_flag_clear: assert property (en && !wake_set |=> !q.wake_req && !q.wake_local)
    else $error("wake flags not cleared");
  a_vcc_low_stby: assert property ((q.mode == lsmc_pkg::LSMC_NORMAL || q.mode == lsmc_pkg::LSMC_SILENT) && vlow && !trip
    |=> q.mode == lsmc_pkg::LSMC_STANDBY) else $error("vcc low ignored");
  a_no_src_flag: assert property (!q.local_var |-> !pins_o.txd_oe && !pins_o.supply_inhibit_output)
    else $error("source flag on bus-only variant");
  a_reg_after_por: assert property (q.mode == lsmc_pkg::LSMC_INIT && !q.aux_ok |-> !pins_o.reg_en)
    else $error("regulator before aux reset");
  a_sleep_only_wake: assert property (q.mode == lsmc_pkg::LSMC_SLEEP && !wake && !trip
    |=> q.mode == lsmc_pkg::LSMC_SLEEP) else $error("sleep left without wake");
  a_bus_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
endmodule : lsmc_top
`default_nettype wire

// [bench/lsmc_mcu_model.sv]
// Node microcontroller model driving the enable and transmit pins
`timescale 1ns/100ps
`default_nettype none
module lsmc_mcu_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_cmd_i,
  input wire logic txd_cmd_i,
  input wire logic txd_oe_i,
  output logic mode_select_o,
  output logic txd_o
);
  logic txd_q;
  // Transmit level and enable are registered on the same edge, so a falling enable sees the level set before it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_q <= 1'h1;
      mode_select_o <= 1'h0;
    end else begin
      txd_q <= txd_cmd_i;
      mode_select_o <= en_cmd_i;
    end
  end
  // Open-drain flag of the device wins over the external pull-up
  assign txd_o = txd_q & ~txd_oe_i;
endmodule : lsmc_mcu_model
`default_nettype wire

// [bench/test_lin_sbc_mode_controller.sv]
// Self-checking bench of the mode controller
`timescale 1ns/100ps
`default_nettype none
module test_lin_sbc_mode_controller;
  logic clk_i = 1'h0, rst_n_i = 1'h0, en = 1'h0, txc = 1'h1, bus = 1'h1, wk = 1'h1, ign = 1'h0;
  logic sok = 1'h0, trip = 1'h0, vlow = 1'h0, aux = 1'h0, trim = 1'h0, rd_i = 1'h0, wr_i = 1'h0;
  logic lvar = 1'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic wreq, msel, txd;
  lsmc_pkg::lsmc_pins_t p;
  int error_cnt = 0, compares = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  lsmc_mcu_model mcu (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_cmd_i(en), .txd_cmd_i(txc),
    .txd_oe_i(p.txd_oe), .mode_select_o(msel), .txd_o(txd));
  // Small counts keep the run short
  lsmc_top #(.STBY_CYC(40), .IGN_CYC(10), .BUS_CYC(4), .PIN_CYC(4), .DOM_CYC(20)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_select_i(msel), .txd_i(txd), .bus_level_i(bus),
    .wake_pin_i(wk), .ignition_wake_i(ign), .supply_ok_i(sok), .supply_trip_i(trip),
    .vcc_low_i(vlow), .aux_por_done_i(aux), .trim_done_i(trim), .trim_local_i(lvar),
    .avs_address_i(adr), .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .pins_o(p));
  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // A hung handshake or poll ends here
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Request holds until waitrequest is sampled low at a rising edge
  task automatic bus_op(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    if (w) wr_i <= 1'h1;
    else rd_i <= 1'h1;
    // Look at the settled answer mid-cycle, then release after the edge that samples it
    forever begin
      @(negedge clk_i);
      if (wreq === 1'h0) break;
    end
    q = rdata;
    @(posedge clk_i);
    rd_i <= 1'h0;
    wr_i <= 1'h0;
  endtask : bus_op
  task automatic wmode(input logic [2:0] m);
    logic [31:0] d;
    for (int i = 0; i < 60; i++) begin
      bus_op(1'h0, 4'h4, 32'h0, d);
      if (d[2:0] === m) break;
    end
    chk("mode", d[2:0], m);
  endtask : wmode
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cycles
  task automatic t_power_up;
    cycles(12);
    chk("aux_en", p.aux_en, 1'h1);
    chk("reg_en", p.reg_en, 1'h0);
    rst_n_i <= 1'h1;
    cycles(4);
    aux <= 1'h1;
    cycles(8);
    chk("reg_en", p.reg_en, 1'h1);
    lvar <= 1'h1;
    trim <= 1'h1;
    sok <= 1'h1;
    wmode(3'h1);
    chk("rxd_oe", p.rxd_oe, 1'h0);
    chk("term_en", p.term_en, 1'h1);
    chk("tx_dom", p.tx_dom, 1'h0);
    chk("inh", p.supply_inhibit_output, 1'h1);
  endtask : t_power_up
  task automatic t_timeout;
    wmode(3'h4);
    chk("reg_en", p.reg_en, 1'h0);
    chk("term_en", p.term_en, 1'h0);
    chk("inh", p.supply_inhibit_output, 1'h0);
  endtask : t_timeout
  task automatic t_remote_wake;
    logic [31:0] d;
    bus <= 1'h0;
    cycles(2);
    bus <= 1'h1;
    cycles(10);
    bus_op(1'h0, 4'h4, 32'h0, d);
    chk("short_dominant", d[2:0], 3'h4);
    bus <= 1'h0;
    cycles(8);
    bus <= 1'h1;
    wmode(3'h1);
    chk("rxd_oe", p.rxd_oe, 1'h1);
    chk("txd_oe", p.txd_oe, 1'h0);
  endtask : t_remote_wake
  task automatic t_normal_tx;
    logic [31:0] d;
    txc <= 1'h0;
    cycles(2);
    en <= 1'h1;
    wmode(3'h2);
    chk("low_slew", p.low_slew, 1'h1);
    chk("rxd_oe", p.rxd_oe, 1'h0);
    chk("unarmed", p.tx_dom, 1'h0);
    txc <= 1'h1;
    cycles(6);
    txc <= 1'h0;
    cycles(6);
    chk("tx_dom", p.tx_dom, 1'h1);
    cycles(30);
    chk("dom_timeout", p.tx_dom, 1'h0);
    bus_op(1'h0, 4'h4, 32'h0, d);
    chk("tx_to", d[8], 1'h1);
    txc <= 1'h1;
    cycles(4);
  endtask : t_normal_tx
  task automatic t_silent;
    logic [31:0] d;
    en <= 1'h0;
    wmode(3'h3);
    chk("term_en", p.term_en, 1'h0);
    chk("bias_en", p.bias_en, 1'h1);
    chk("reg_en", p.reg_en, 1'h1);
    chk("inh", p.supply_inhibit_output, 1'h0);
    en <= 1'h1;
    wmode(3'h2);
    en <= 1'h0;
    wmode(3'h3);
    bus_op(1'h1, 4'h0, 32'h1, d);
    wk <= 1'h0;
    cycles(10);
    wk <= 1'h1;
    cycles(6);
    bus_op(1'h0, 4'h4, 32'h0, d);
    chk("masked", d[2:0], 3'h3);
    bus_op(1'h0, 4'h8, 32'h0, d);
    chk("unmapped", d, 32'h0);
    bus_op(1'h1, 4'h0, 32'h0, d);
    wk <= 1'h0;
    cycles(10);
    wk <= 1'h1;
    wmode(3'h1);
    chk("txd_oe", p.txd_oe, 1'h1);
    chk("txd", txd, 1'h0);
    en <= 1'h1;
    wmode(3'h2);
    chk("flags", {p.rxd_oe, p.txd_oe}, 2'h0);
  endtask : t_silent
  task automatic t_vcc_low;
    vlow <= 1'h1;
    wmode(3'h1);
    vlow <= 1'h0;
    en <= 1'h0;
    cycles(6);
    en <= 1'h1;
    wmode(3'h2);
  endtask : t_vcc_low
  task automatic t_ignition;
    txc <= 1'h0;
    cycles(3);
    en <= 1'h0;
    wmode(3'h4);
    txc <= 1'h1;
    ign <= 1'h1;
    wmode(3'h1);
    chk("txd_oe", p.txd_oe, 1'h1);
    en <= 1'h1;
    wmode(3'h2);
    trip <= 1'h1;
    wmode(3'h0);
  endtask : t_ignition
  initial begin
    t_power_up();
    t_timeout();
    t_remote_wake();
    t_normal_tx();
    t_silent();
    t_vcc_low();
    t_ignition();
    end_of_test();
  end
endmodule : test_lin_sbc_mode_controller
`default_nettype wire
